// >>> design/dcasc_top.v
// serial control and sequencing of the two-channel 12-bit sampling converter
`timescale 1ns/1ps
`default_nettype none
`include "dcasc_defs.vh"

module dcasc_top (
    input wire sys_clk_in,
    input wire rst_in,
    input wire cs_n_in,
    input wire sclk_in,
    input wire din_in,
    output wire dout_out,
    output wire dout_oe_out,
    output wire sample_req_out,
    output wire sample_chan_out,
    output wire track_out,
    output wire hold_out,
    output wire power_down_out,
    output wire underrun_out,
    output wire addr_fault_out,
    input wire [`DCASC_RES_BITS-1:0] result_data_in,
    input wire result_valid_in,
    output wire result_ready_out
);
    // ------------------------------------------------------------------
    // pin synchronisers and edge detection
    // ------------------------------------------------------------------
    wire [2:0] pins_f;
    wire cs_n_f;
    wire sclk_f;
    wire din_f;
    reg cs_n_d_r;
    reg sclk_d_r;

    dcasc_sync #(
        .WIDTH(`DCASC_SYNC_BITS)
    ) u_sync (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .pin_in({din_in, sclk_in, cs_n_in}),
        .level_out(pins_f)
    );

    assign cs_n_f = pins_f[0];
    assign sclk_f = pins_f[1];
    assign din_f = pins_f[2];

    // previous filtered levels for edge detection
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cs_n_d_r <= 1'b1;
            sclk_d_r <= 1'b1;
        end else begin
            cs_n_d_r <= cs_n_f;
            sclk_d_r <= sclk_f;
        end
    end

    wire cs_fall;
    wire sclk_rise;
    wire sclk_fall_raw;
    wire fall_evt;
    // clock is gated off while select is high
    assign cs_fall = cs_n_d_r && !cs_n_f;
    assign sclk_rise = !cs_n_f && !cs_n_d_r && !sclk_d_r && sclk_f;
    assign sclk_fall_raw = !cs_n_f && !cs_n_d_r && sclk_d_r && !sclk_f;
    // select falling onto a low clock counts as the first falling edge
    assign fall_evt = sclk_fall_raw || (cs_fall && !sclk_f);

    // ------------------------------------------------------------------
    // result buffer
    // ------------------------------------------------------------------
    wire [`DCASC_RES_BITS-1:0] fifo_data;
    wire fifo_valid;
    wire fifo_pop;

    dcasc_fifo #(
        .WIDTH(`DCASC_RES_BITS),
        .DEPTH(`DCASC_FIFO_DEPTH),
        .AW(`DCASC_FIFO_AW)
    ) u_fifo (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .wr_data_in(result_data_in),
        .wr_valid_in(result_valid_in),
        .wr_ready_out(result_ready_out),
        .rd_data_out(fifo_data),
        .rd_valid_out(fifo_valid),
        .rd_ready_in(fifo_pop)
    );

    // ------------------------------------------------------------------
    // counters and control word capture
    // ------------------------------------------------------------------
    reg [4:0] fall_cnt_r;
    reg [3:0] rise_cnt_r;
    reg [7:0] ctrl_sh_r;
    reg next_chan_r;
    reg cur_chan_r;
    reg addr_fault_r;
    wire conv_start;
    wire hold_start;
    wire [7:0] ctrl_word;
    wire ctrl_done;

    // a fall at count 0 or 16 opens a fresh conversion; back to back needs no gap
    assign conv_start = fall_evt && ((fall_cnt_r == 5'h00) || (fall_cnt_r == `DCASC_CONV_CLKS));
    assign hold_start = fall_evt && (fall_cnt_r == `DCASC_TRACK_CLKS);
    assign ctrl_word = {ctrl_sh_r[6:0], din_f};
    // eighth rise of a conversion completes the control word
    assign ctrl_done = sclk_rise && (rise_cnt_r == `DCASC_CTRL_LAST);

    // falling-edge position within the conversion, 0 = waiting for first fall
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            fall_cnt_r <= 5'h00;
        end else if (cs_n_f) begin
            fall_cnt_r <= 5'h00;
        end else if (conv_start) begin
            fall_cnt_r <= 5'h01;
        end else if (fall_evt) begin
            fall_cnt_r <= fall_cnt_r + 5'h01;
        end
    end

    // rising-edge position; four bits wrap after sixteen edges
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rise_cnt_r <= 4'h0;
        end else if (cs_fall || cs_n_f) begin
            rise_cnt_r <= 4'h0;
        end else if (sclk_rise) begin
            rise_cnt_r <= rise_cnt_r + 4'h1;
        end
    end

    // capture control word on the first eight rising edges of each conversion
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_sh_r <= 8'h00;
            next_chan_r <= `DCASC_CHAN_RESET;
            addr_fault_r <= 1'b0;
        end else if (sclk_rise && (rise_cnt_r < `DCASC_CTRL_BITS)) begin
            ctrl_sh_r <= ctrl_word;
            if (ctrl_done) begin
                // only the low address bit steers; the middle bit raises the fault, the rest are don't-care
                next_chan_r <= ctrl_word[`DCASC_ADDR_LOW_POS];
                // middle bit set is outside the contract; flagged, output undefined
                addr_fault_r <= ctrl_word[`DCASC_ADDR_MID_POS];
            end
        end
    end

    // channel for this conversion is the one requested during the previous one
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cur_chan_r <= `DCASC_CHAN_RESET;
        end else if (conv_start) begin
            cur_chan_r <= next_chan_r;
        end
    end

    // ------------------------------------------------------------------
    // serial output shifter
    // ------------------------------------------------------------------
    reg [`DCASC_RES_BITS-1:0] out_sh_r;
    reg dout_r;
    reg dout_oe_r;
    reg underrun_r;
    reg sample_req_r;
    wire shift_win;

    // pop only on the hold start; an empty buffer sends zeros
    assign fifo_pop = hold_start;

    // falls five to sixteen each move one result bit; the fourth only loads
    assign shift_win = (fall_cnt_r > `DCASC_TRACK_CLKS) && (fall_cnt_r < `DCASC_CONV_CLKS);

    // data changes on falling edges so the host samples it on rising ones
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            out_sh_r <= {`DCASC_RES_BITS{1'b0}};
            dout_r <= 1'b0;
            underrun_r <= 1'b0;
        end else if (cs_n_f) begin
            dout_r <= 1'b0;
        end else if (fall_evt) begin
            if (hold_start) begin
                // straight binary loaded untouched; MSB leaves on the fifth clock
                out_sh_r <= fifo_valid ? fifo_data : {`DCASC_RES_BITS{1'b0}};
                dout_r <= 1'b0;
                underrun_r <= !fifo_valid;
            end else if (shift_win) begin
                dout_r <= out_sh_r[`DCASC_RES_BITS-1];
                out_sh_r <= {out_sh_r[`DCASC_RES_BITS-2:0], 1'b0};
            end else begin
                // first three bit periods read as zero; the LSB stays out through the power-down tail
                dout_r <= 1'b0;
            end
        end
    end

    // output driven only while select is low
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            dout_oe_r <= 1'b0;
        end else begin
            dout_oe_r <= !cs_n_f;
        end
    end

    // one-cycle request to the analog core at track start
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sample_req_r <= 1'b0;
        end else begin
            sample_req_r <= conv_start;
        end
    end

    // ------------------------------------------------------------------
    // power and mode decode
    // ------------------------------------------------------------------
    localparam PM_DOWN = 2'b00;
    localparam PM_WAKE = 2'b01;
    localparam PM_TRACK = 2'b10;
    localparam PM_HOLD = 2'b11;
    reg [1:0] pm_state;
    reg track_c;
    reg hold_c;
    reg down_c;

    // position in the conversion picks the mode; select high overrides all
    always @* begin
        pm_state = PM_DOWN;
        if (cs_n_f) begin
            pm_state = PM_DOWN;
        end else if (fall_cnt_r == 5'h00) begin
            // selected, first fall not yet seen: powered and idle
            pm_state = PM_WAKE;
        end else if (fall_cnt_r <= `DCASC_TRACK_CLKS) begin
            pm_state = PM_TRACK;
        end else if (fall_cnt_r < `DCASC_CONV_CLKS) begin
            pm_state = PM_HOLD;
        end else begin
            // sixteenth fall until the next first fall
            pm_state = PM_DOWN;
        end
    end

    // at most one level per mode (none in wake), so track, hold and power-down never overlap
    always @* begin
        track_c = 1'b0;
        hold_c = 1'b0;
        down_c = 1'b0;
        case (pm_state)
            PM_TRACK: begin
                track_c = 1'b1;
            end
            PM_HOLD: begin
                hold_c = 1'b1;
            end
            PM_WAKE: begin
                // powered while selected, waiting for the first fall
                down_c = 1'b0;
            end
            default: begin
                down_c = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign dout_out = dout_r;
    assign dout_oe_out = dout_oe_r;
    assign sample_req_out = sample_req_r;
    assign sample_chan_out = cur_chan_r;
    assign track_out = track_c;
    assign hold_out = hold_c;
    // down while deselected or from the sixteenth fall until the next first fall
    assign power_down_out = down_c;
    assign underrun_out = underrun_r;
    assign addr_fault_out = addr_fault_r;
endmodule // dcasc_top
`default_nettype wire

// >>> design/dcasc_defs.vh
// constants shared by the serial control block of the two-channel converter
`ifndef DCASC_DEFS_VH
`define DCASC_DEFS_VH

// ----------------------------------------------------------------------
// conversion framing
// ----------------------------------------------------------------------
`define DCASC_CONV_CLKS 5'h10
`define DCASC_TRACK_CLKS 5'h03
`define DCASC_HOLD_FALL 5'h04
`define DCASC_CTRL_BITS 4'h8
`define DCASC_CTRL_LAST 4'h7

// ----------------------------------------------------------------------
// channel_select_control field positions and reset value
// ----------------------------------------------------------------------
`define DCASC_ADDR_LOW_POS 3
`define DCASC_ADDR_MID_POS 4
`define DCASC_ADDR_TOP_POS 5
`define DCASC_CHAN_RESET 1'b0

// ----------------------------------------------------------------------
// result path
// ----------------------------------------------------------------------
`define DCASC_RES_BITS 12
`define DCASC_FIFO_DEPTH 8
`define DCASC_FIFO_AW 3
`define DCASC_SYNC_BITS 3

`endif

// >>> design/dcasc_sync.v
// three-stage pin synchroniser with agreement filter, one per bit
`timescale 1ns/1ps
`default_nettype none
module dcasc_sync #(
    parameter WIDTH = 3
) (
    input wire sys_clk_in,
    input wire rst_in,
    input wire [WIDTH-1:0] pin_in,
    output wire [WIDTH-1:0] level_out
);
    reg [WIDTH-1:0] s1_r;
    reg [WIDTH-1:0] s2_r;
    reg [WIDTH-1:0] s3_r;
    reg [WIDTH-1:0] lvl_r;
    genvar i;

    // ------------------------------------------------------------------
    // per-bit chain
    // ------------------------------------------------------------------
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            // first stage only feeds the second; level moves when stages two and three agree
            always @(posedge sys_clk_in or posedge rst_in) begin
                if (rst_in) begin
                    s1_r[i] <= 1'b1;
                    s2_r[i] <= 1'b1;
                    s3_r[i] <= 1'b1;
                    lvl_r[i] <= 1'b1;
                end else begin
                    s1_r[i] <= pin_in[i];
                    s2_r[i] <= s1_r[i];
                    s3_r[i] <= s2_r[i];
                    if (s2_r[i] == s3_r[i]) begin
                        lvl_r[i] <= s3_r[i];
                    end
                end
            end
        end
    endgenerate

    // all stages reset to the idle high level, so select reads deasserted
    assign level_out = lvl_r;
endmodule // dcasc_sync
`default_nettype wire

// >>> design/dcasc_fifo.v
// result buffer between the converter core and the serial shifter
`timescale 1ns/1ps
`default_nettype none
module dcasc_fifo #(
    parameter WIDTH = 12,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire sys_clk_in,
    input wire rst_in,
    input wire [WIDTH-1:0] wr_data_in,
    input wire wr_valid_in,
    output wire wr_ready_out,
    output wire [WIDTH-1:0] rd_data_out,
    output wire rd_valid_out,
    input wire rd_ready_in
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    reg [AW:0] count_r;
    wire push;
    wire pop;

    // ------------------------------------------------------------------
    // handshakes
    // ------------------------------------------------------------------
    assign wr_ready_out = (count_r != DEPTH[AW:0]);
    assign rd_valid_out = (count_r != {(AW+1){1'b0}});
    assign push = wr_valid_in && wr_ready_out;
    assign pop = rd_ready_in && rd_valid_out;
    assign rd_data_out = mem_r[rd_ptr_r];

    // storage has no reset; only the pointers and the count carry state
    always @(posedge sys_clk_in) begin
        if (push) begin
            mem_r[wr_ptr_r] <= wr_data_in;
        end
    end

    // pointers wrap naturally, depth is a power of two
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule // dcasc_fifo
`default_nettype wire

// >>> verification/dcasc_top_asserts.sv
// checker on the pins of the converter serial control block
`timescale 1ns/1ps
`default_nettype none
module dcasc_top_asserts (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic cs_n_in,
    input wire logic dout_out,
    input wire logic dout_oe_out,
    input wire logic sample_req_out,
    input wire logic sample_chan_out,
    input wire logic track_out,
    input wire logic hold_out,
    input wire logic power_down_out
);
    // one clock domain, so clock and reset are given once
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    // eight steady clocks cover the pin filter latency with margin
    property p_oe_cs; $stable(cs_n_in) [*8] |-> dout_oe_out == !cs_n_in; endproperty
    a_oe_cs: assert property (p_oe_cs) else $error("enable not following select");
    property p_pd_cs; cs_n_in [*8] |-> power_down_out && !track_out && !hold_out; endproperty
    a_pd_cs: assert property (p_pd_cs) else $error("active while deselected");
    property p_hold_end; $fell(hold_out) |-> power_down_out; endproperty
    a_hold_end: assert property (p_hold_end) else $error("hold ended without power down");
    // wake may come one clock before the count when select is what falls
    property p_wake; $fell(power_down_out) |-> ##[0:1] track_out; endproperty
    a_wake: assert property (p_wake) else $error("wake without track");
    property p_req; $rose(track_out) |-> ##[0:1] sample_req_out ##1 !sample_req_out; endproperty
    a_req: assert property (p_req) else $error("no single start pulse");
    property p_track_end; $fell(track_out) |-> hold_out || power_down_out; endproperty
    a_track_end: assert property (p_track_end) else $error("track not followed by hold");
    property p_track_zero; track_out [*3] |-> !dout_out; endproperty
    a_track_zero: assert property (p_track_zero) else $error("data out not zero in track");
    // the first hold period still carries a leading zero; data starts on the fifth clock
    property p_lead_zero; $rose(hold_out) |-> (!dout_out) [*8]; endproperty
    a_lead_zero: assert property (p_lead_zero) else $error("result started before fifth clock");
    property p_chan; $changed(sample_chan_out) |-> sample_req_out || $past(sample_req_out); endproperty
    a_chan: assert property (p_chan) else $error("channel moved outside start");
endmodule // dcasc_top_asserts

bind dcasc_top dcasc_top_asserts u_chk (.sys_clk_in, .rst_in, .cs_n_in, .dout_out, .dout_oe_out,
    .sample_req_out, .sample_chan_out, .track_out, .hold_out, .power_down_out);
`default_nettype wire

// >>> verification/dcasc_host_model.sv
// host serial master model for the select, clock and data pins
`timescale 1ns/1ps
`default_nettype none
module dcasc_host_model (
    input wire logic sys_clk_in,
    input wire logic dout_in,
    output logic cs_n_out,
    output logic sclk_out,
    output logic din_out,
    output logic [15:0] word_out,
    output logic word_valid_out
);
    // eight system clocks a half period: slow, and the pin filter settles first
    localparam int HALF = 8;
    // select idles high, clock parked low
    initial {cs_n_out, sclk_out, din_out, word_valid_out, word_out} = 20'h80000;
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask
    // one conversion; the last of a frame lifts select with the clock high
    task automatic conv(input logic [7:0] ctrl, input logic last);
        cs_n_out = 1'b0;
        for (int k = 0; k < 16; k++) begin
            sclk_out = 1'b0;
            din_out = (k < 8) ? ctrl[7-k] : ~din_out;
            tick(HALF);
            sclk_out = 1'b1;
            word_out = {word_out[14:0], dout_in};
            tick(HALF);
        end
        word_valid_out = 1'b1;
        tick(1);
        word_valid_out = 1'b0;
        if (last) begin
            cs_n_out = 1'b1;
            tick(HALF);
            sclk_out = 1'b0;
            tick(HALF);
        end
    endtask
endmodule // dcasc_host_model
`default_nettype wire

// >>> verification/dcasc_top_bench.sv
// self-checking bench for the converter serial control block
`timescale 1ns/1ps
`default_nettype none
module dcasc_top_bench;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [11:0] result_data_in = 12'h0;
    logic result_valid_in = 1'b0;
    logic dout_last_r = 1'b0;
    logic hold_d_r = 1'b0;
    wire logic cs_n_in, sclk_in, din_in, dout_out, dout_oe_out, sample_req_out, sample_chan_out;
    wire logic track_out, hold_out, power_down_out, underrun_out, addr_fault_out, result_ready_out;
    wire logic word_valid;
    wire logic [15:0] word;
    // a released pin shows the inverse of its last driven level
    wire logic dout_pin = dout_oe_out ? dout_out : ~dout_last_r;
    int n_errors = 0;
    int samples_checked = 0;
    logic [15:0] q_word[$];
    logic q_chan[$];
    logic [11:0] q_res[$];
    dcasc_top u_dut (.sys_clk_in, .rst_in, .cs_n_in, .sclk_in, .din_in, .dout_out, .dout_oe_out,
        .sample_req_out, .sample_chan_out, .track_out, .hold_out, .power_down_out, .underrun_out,
        .addr_fault_out, .result_data_in, .result_valid_in, .result_ready_out);
    dcasc_host_model u_host (.sys_clk_in, .dout_in(dout_pin), .cs_n_out(cs_n_in), .sclk_out(sclk_in),
        .din_out(din_in), .word_out(word), .word_valid_out(word_valid));
    initial forever #25 sys_clk_in = ~sys_clk_in;
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("errors %0d comparisons %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // offer one result; bounded wait, ok tells whether it was taken
    task automatic push(input logic [11:0] d, output logic ok);
        @(posedge sys_clk_in);
        #1;
        {result_data_in, result_valid_in, ok} = {d, 2'b10};
        repeat (4) begin
            if (ok !== 1'b1) begin
                @(posedge sys_clk_in);
                ok = result_ready_out;
                #1;
            end
        end
        result_valid_in = 1'b0;
    endtask
    // finished words and hold starts are held against the oldest note
    always @(posedge sys_clk_in) begin
        dout_last_r <= dout_oe_out ? dout_out : dout_last_r;
        hold_d_r <= hold_out;
        if (word_valid === 1'b1) check(word, q_word.size() ? q_word.pop_front() : 16'hxxxx);
        if (hold_out === 1'b1 && hold_d_r !== 1'b1) check(sample_chan_out, q_chan.pop_front());
    end
    initial begin
        logic [7:0] ctrl;
        logic [11:0] d;
        logic ok;
        logic next_ch;
        void'($urandom(32'hb91d));
        repeat (4) @(posedge sys_clk_in);
        #1;
        rst_in = 1'b0;
        check({power_down_out, dout_oe_out, sample_chan_out}, 3'b100);
        // fill the buffer until it refuses
        for (int i = 0; i < 9; i++) begin
            d = 12'($urandom);
            push(d, ok);
            check(ok, i < 8);
            if (i < 8) q_res.push_back(d);
        end
        // two frames back to back, channel walking, junk in ignored bits
        next_ch = 1'b0;
        for (int i = 0; i < 10; i++) begin
            ctrl = (8'($urandom) & 8'hc7) | {2'b00, i[1], 1'b0, i[0], 3'b000};
            q_chan.push_back(next_ch);
            q_word.push_back(q_res.size() ? {4'h0, q_res.pop_front()} : 16'h0);
            u_host.conv(ctrl, i == 4 || i == 9);
            next_ch = ctrl[3];
            if (i == 0) check(underrun_out, 1'b0);
            if (i == 4) check({power_down_out, dout_oe_out}, 2'b10);
        end
        check(underrun_out, 1'b1);
        // middle address bit set on purpose, then a legal word
        push(12'h5a3, ok);
        check(ok, 1'b1);
        q_chan.push_back(next_ch);
        q_word.push_back({4'h0, 12'h5a3});
        u_host.conv(8'h10, 1'b0);
        check({addr_fault_out, underrun_out}, 2'b10);
        q_chan.push_back(1'b0);
        q_word.push_back(16'h0);
        u_host.conv(8'h00, 1'b1);
        check({addr_fault_out, underrun_out}, 2'b01);
        repeat (4) @(posedge sys_clk_in);
        check(16'(q_word.size() + q_chan.size()), 16'h0);
        report_and_stop();
    end
endmodule // dcasc_top_bench
`default_nettype wire
